// ===== logic/gpio_port_pkg.sv
// Constants for the packet-controlled five-pin port.
// Assumes a 250 MHz core clock and a 32-bit AXI4-Lite register bus.
`default_nettype none

package gpio_port_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFFS_CMD    = 8'h00; // Command type and length, write executes
  localparam logic [7:0] OFFS_ARG    = 8'h04; // Command data bytes 0..2
  localparam logic [7:0] OFFS_RHDR   = 8'h08; // Answer type and length
  localparam logic [7:0] OFFS_RDATA  = 8'h0c; // Answer data bytes 0..3
  localparam logic [7:0] OFFS_STATUS = 8'h10; // Live levels and edge flags

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CMD_LEN_LSB   = 8;
  localparam int STAT_RISE_LSB = 8;
  localparam int STAT_FALL_LSB = 16;
  localparam int RD_LEVEL_BIT  = 0;
  localparam int RD_FALL_BIT   = 1;
  localparam int RD_RISE_BIT   = 2;
  localparam int CFG_FUNC_BIT  = 3;

  // ---------------------------------------------------------------
  // Command codes and answer marks
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_STORE_BOOT = 8'h04;
  localparam logic [7:0] CMD_SET_GPIO   = 8'h22;
  localparam logic [7:0] CMD_READ_GPIO  = 8'h23;
  localparam logic [7:0] ACK_MARK       = 8'h40;
  localparam logic [7:0] ERR_MARK       = 8'h80;
  localparam logic [7:0] LEVEL_HIGH     = 8'h64; // 100 percent
  localparam logic [2:0] LEN_SHORT      = 3'h2;
  localparam logic [2:0] LEN_LONG       = 3'h3;
  localparam logic [2:0] LEN_QUERY      = 3'h1;
  localparam logic [7:0] READ_ANS_LEN   = 8'h04;

  // ---------------------------------------------------------------
  // Drive modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DM_FAST_UP_PULL_DN = 3'h0,
    DM_FAST_BOTH       = 3'h1,
    DM_HIZ_INPUT       = 3'h2,
    DM_PULL_UP_FAST_DN = 3'h3,
    DM_SLOW_UP_HIZ     = 3'h4,
    DM_SLOW_BOTH       = 3'h5,
    DM_RESERVED        = 3'h6,
    DM_HIZ_SLOW_DN     = 3'h7
  } drive_mode_type;

  // ---------------------------------------------------------------
  // Factory boot state, one nibble {function, drive mode} and one value byte per pin
  // ---------------------------------------------------------------
  localparam logic [19:0] FACTORY_CFG   = 20'h72232;
  localparam logic [39:0] FACTORY_VALUE = 40'h00_0000_0000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_FREQ_HZ    = 250_000_000;
  localparam longint PWM_FREQ_HZ    = 100;
  localparam longint PWM_STEPS      = 100;
  localparam longint SAMPLE_FREQ_HZ = 32;
  localparam longint PWM_STEP_CYC   = CLK_FREQ_HZ / (PWM_FREQ_HZ * PWM_STEPS);
  localparam longint SAMPLE_CYC     = CLK_FREQ_HZ / SAMPLE_FREQ_HZ;

endpackage : gpio_port_pkg

`default_nettype wire

// ===== logic/packet_gpio_port.sv
// Five-pin general-purpose port driven by command packets over AXI4-Lite.
// Assumes same-clock shared-function logic and pads with
// output, enable, pull and slew controls.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`default_nettype none

module packet_gpio_port #(
  parameter int unsigned PWM_STEP_CYCLES = int'(gpio_port_pkg::PWM_STEP_CYC),
  parameter int unsigned SAMPLE_CYCLES   = int'(gpio_port_pkg::SAMPLE_CYC)
) (
  // Clock and resets
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        POR_I,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  // AXI4-Lite write response
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  // AXI4-Lite read
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  // Shared default functions
  input  wire logic [4:0]  ALT_LEVEL_I,
  output logic [4:0]       PIN_LEVEL_O,
  output logic [4:0]       USER_CTRL_O,
  // Pads
  input  wire logic [4:0]  GPIO_I,
  output logic [4:0]       GPIO_O,
  output logic [4:0]       GPIO_OE_O,
  output logic [4:0]       GPIO_PULLUP_O,
  output logic [4:0]       GPIO_PULLDN_O,
  output logic [4:0]       GPIO_SLOW_O
);

  localparam int NPINS = 5;
  localparam int STEP_W = $clog2(PWM_STEP_CYCLES + 1);
  localparam int SAMP_W = $clog2(SAMPLE_CYCLES + 1);

  // -------------------------------------------------------------
  // Elaboration checks
  // -------------------------------------------------------------
  if (PWM_STEP_CYCLES < 1) begin : g_bad_step
    $error("PWM_STEP_CYCLES must be at least 1");
  end
  if (SAMPLE_CYCLES < 2) begin : g_bad_sample
    $error("SAMPLE_CYCLES must be at least 2");
  end

  typedef enum logic [0:0] {WR_COLLECT = 1'b0, WR_RESP = 1'b1} wr_state_type;
  typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_DATA = 1'b1} rd_state_type;

  // Drive resolution: {o, oe, pull-up, pull-down, slow}
  function automatic logic [4:0] resolve(input logic [2:0] mode, input logic level);
    case (mode)
      gpio_port_pkg::DM_FAST_UP_PULL_DN: resolve = level ? 5'h18 : 5'h02;
      gpio_port_pkg::DM_FAST_BOTH:       resolve = {level, 4'h8};
      gpio_port_pkg::DM_HIZ_INPUT:       resolve = 5'h00;
      gpio_port_pkg::DM_PULL_UP_FAST_DN: resolve = level ? 5'h04 : 5'h08;
      gpio_port_pkg::DM_SLOW_UP_HIZ:     resolve = level ? 5'h19 : 5'h00;
      gpio_port_pkg::DM_SLOW_BOTH:       resolve = {level, 4'h9};
      gpio_port_pkg::DM_HIZ_SLOW_DN:     resolve = level ? 5'h00 : 5'h09;
      default:                           resolve = 5'h00; // Reserved code floats
    endcase
  endfunction : resolve

  // Pin index in range
  function automatic logic index_ok(input logic [7:0] idx);
    index_ok = (idx < 8'(NPINS));
  endfunction : index_ok

  // -------------------------------------------------------------
  // Configuration state
  // -------------------------------------------------------------
  logic [7:0]  value [NPINS];
  logic [3:0]  cfg   [NPINS];
  logic [7:0]  boot_value [NPINS];
  logic [3:0]  boot_cfg   [NPINS];
  logic [31:0] arg;
  logic [7:0]  ans_type;
  logic [7:0]  ans_len;
  logic [31:0] ans_data;

  // -------------------------------------------------------------
  // AXI4-Lite write side
  // -------------------------------------------------------------
  wr_state_type wr_state;
  logic         aw_held;
  logic         w_held;
  logic [7:0]   awaddr_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         aw_fire;
  logic         w_fire;
  logic         do_write;
  logic [7:0]   wr_addr;
  logic [31:0]  wr_data;
  logic [3:0]   wr_strb;
  logic         wr_mapped;

  // Combinational handshakes; channels may arrive in any order
  assign AWREADY_O = (wr_state == WR_COLLECT) && !aw_held;
  assign WREADY_O  = (wr_state == WR_COLLECT) && !w_held;
  assign aw_fire   = AWVALID_I && AWREADY_O;
  assign w_fire    = WVALID_I && WREADY_O;
  assign do_write  = (wr_state == WR_COLLECT) && (aw_held || aw_fire) && (w_held || w_fire);
  assign wr_addr   = aw_held ? awaddr_q : AWADDR_I;
  assign wr_data   = w_held ? wdata_q : WDATA_I;
  assign wr_strb   = w_held ? wstrb_q : WSTRB_I;
  assign BVALID_O  = (wr_state == WR_RESP);
  assign wr_mapped = (wr_addr == gpio_port_pkg::OFFS_CMD) || (wr_addr == gpio_port_pkg::OFFS_ARG);

  // Hold whichever half arrived first
  always_ff @(posedge CLK_I) begin
    if (RESET_I || do_write) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_held  <= 1'b1;
      end
      if (w_fire) begin
        w_held   <= 1'b1;
      end
    end
    if (aw_fire) begin
      awaddr_q <= AWADDR_I;
    end
    if (w_fire) begin
      wdata_q <= WDATA_I;
      wstrb_q <= WSTRB_I;
    end
  end

  // Write response; read-only or unmapped offsets answer SLVERR
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      wr_state <= WR_COLLECT;
      BRESP_O  <= 2'h0;
    end else if (do_write) begin
      wr_state <= WR_RESP;
      BRESP_O  <= wr_mapped ? 2'h0 : 2'h2;
    end else if (BVALID_O && BREADY_I) begin
      wr_state <= WR_COLLECT;
    end
  end

  // Argument bytes, merged by strobe
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      arg <= 32'h0;
    end else if (do_write && wr_addr == gpio_port_pkg::OFFS_ARG) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_strb[b]) begin
          arg[8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
    end
  end

  // -------------------------------------------------------------
  // Command decode
  // -------------------------------------------------------------
  logic       cmd_go;
  logic [7:0] cmd_type;
  logic [2:0] cmd_len;
  logic [7:0] a_idx;
  logic [7:0] a_val;
  logic [7:0] a_cfg;
  logic [2:0] pin;
  logic       set_ok;
  logic       read_ok;
  logic       store_ok;

  assign cmd_go   = do_write && (wr_addr == gpio_port_pkg::OFFS_CMD) && wr_strb[0];
  assign cmd_type = wr_data[7:0];
  assign cmd_len  = wr_data[gpio_port_pkg::CMD_LEN_LSB +: 3];
  assign a_idx    = arg[7:0];
  assign a_val    = arg[15:8];
  assign a_cfg    = arg[23:16];
  assign pin      = a_idx[2:0];
  // Bad index, length or value changes nothing
  assign set_ok   = (cmd_type == gpio_port_pkg::CMD_SET_GPIO) && index_ok(a_idx)
                 && (a_val <= gpio_port_pkg::LEVEL_HIGH)
                 && (cmd_len == gpio_port_pkg::LEN_SHORT || cmd_len == gpio_port_pkg::LEN_LONG);
  assign read_ok  = (cmd_type == gpio_port_pkg::CMD_READ_GPIO) && index_ok(a_idx)
                 && (cmd_len == gpio_port_pkg::LEN_QUERY);
  assign store_ok = (cmd_type == gpio_port_pkg::CMD_STORE_BOOT) && (cmd_len == 3'h0);

  // -------------------------------------------------------------
  // Input sampling, debounce and edge memory
  // -------------------------------------------------------------
  logic [4:0]        sync1;
  logic [4:0]        sync2;
  logic [SAMP_W-1:0] samp_cnt;
  logic              samp_tick;
  logic [4:0]        last_sample;
  logic [4:0]        stable;
  logic [4:0]        rise;
  logic [4:0]        fall;
  logic [4:0]        next_stable;
  logic [4:0]        rd_clear;

  // Two-stage synchroniser on the pads
  always_ff @(posedge CLK_I) begin
    sync1 <= GPIO_I;
    sync2 <= sync1;
  end

  // Free-running 32 Hz tick, whatever the configuration
  always_ff @(posedge CLK_I) begin
    if (RESET_I || samp_tick) begin
      samp_cnt <= '0;
    end else begin
      samp_cnt <= samp_cnt + 1'b1;
    end
  end
  assign samp_tick = (samp_cnt == SAMP_W'(SAMPLE_CYCLES - 1));

  // A level counts only after two equal samples, so bounce shorter
  // than one sample period never reaches the flags
  assign next_stable = samp_tick ? ((sync2 & last_sample) | (stable & (sync2 ^ last_sample))) : stable;
  assign rd_clear    = (read_ok && cmd_go) ? 5'(1 << pin) : 5'h0;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      last_sample <= 5'h0;
      stable      <= 5'h0;
    end else begin
      if (samp_tick) begin
        last_sample <= sync2;
      end
      stable <= next_stable;
    end
  end

  // Sticky edges: a new edge wins over the clear from a read
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rise <= 5'h0;
      fall <= 5'h0;
    end else begin
      rise <= (rise & ~rd_clear) | (next_stable & ~stable);
      fall <= (fall & ~rd_clear) | (~next_stable & stable);
    end
  end
  assign PIN_LEVEL_O = stable;

  // -------------------------------------------------------------
  // Live and boot configuration
  // -------------------------------------------------------------
  // Boot copy survives RESET_I; only power-on loads factory values
  always_ff @(posedge CLK_I) begin
    for (int p = 0; p < NPINS; p++) begin
      if (POR_I) begin
        boot_value[p] <= gpio_port_pkg::FACTORY_VALUE[8*p +: 8];
        boot_cfg[p]   <= gpio_port_pkg::FACTORY_CFG[4*p +: 4];
      end else if (cmd_go && store_ok) begin
        boot_value[p] <= value[p];
        boot_cfg[p]   <= cfg[p];
      end
    end
  end

  // Reset reapplies the boot copy; set command updates one pin
  always_ff @(posedge CLK_I) begin
    for (int p = 0; p < NPINS; p++) begin
      if (RESET_I) begin
        value[p] <= POR_I ? gpio_port_pkg::FACTORY_VALUE[8*p +: 8] : boot_value[p];
        cfg[p]   <= POR_I ? gpio_port_pkg::FACTORY_CFG[4*p +: 4] : boot_cfg[p];
      end else if (cmd_go && set_ok && pin == 3'(p)) begin
        value[p] <= a_val;
        if (cmd_len == gpio_port_pkg::LEN_LONG) begin
          cfg[p] <= a_cfg[3:0]; // Reserved upper bits dropped
        end
      end
    end
  end

  // Answer packet: ack sets bit 6, failure sets bit 7
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ans_type <= 8'h0;
      ans_len  <= 8'h0;
      ans_data <= 32'h0;
    end else if (cmd_go) begin
      ans_len  <= 8'h0;
      ans_data <= 32'h0;
      if (set_ok || store_ok) begin
        ans_type <= cmd_type | gpio_port_pkg::ACK_MARK;
      end else if (read_ok) begin
        ans_type <= cmd_type | gpio_port_pkg::ACK_MARK;
        ans_len  <= gpio_port_pkg::READ_ANS_LEN;
        ans_data[7:0] <= a_idx;
        ans_data[8 + gpio_port_pkg::RD_LEVEL_BIT] <= stable[pin];
        ans_data[8 + gpio_port_pkg::RD_FALL_BIT]  <= fall[pin];
        ans_data[8 + gpio_port_pkg::RD_RISE_BIT]  <= rise[pin];
        ans_data[23:16] <= value[pin];
        ans_data[27:24] <= cfg[pin];
      end else begin
        ans_type <= cmd_type | gpio_port_pkg::ERR_MARK;
      end
    end
  end

  // -------------------------------------------------------------
  // PWM timebase: 100 steps of one percent each
  // -------------------------------------------------------------
  logic [STEP_W-1:0] step_cnt;
  logic [6:0]        pct;
  logic              step_tick;

  assign step_tick = (step_cnt == STEP_W'(PWM_STEP_CYCLES - 1));
  always_ff @(posedge CLK_I) begin
    if (RESET_I || step_tick) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + 1'b1;
    end
  end

  // One full sweep of pct is the 100 Hz period
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      pct <= 7'h0;
    end else if (step_tick) begin
      pct <= (pct == 7'(gpio_port_pkg::PWM_STEPS - 1)) ? 7'h0 : pct + 7'h1;
    end
  end

  // -------------------------------------------------------------
  // Per-pin drive
  // -------------------------------------------------------------
  for (genvar g = 0; g < NPINS; g++) begin : g_pin
    logic       user_level;
    logic       level;
    logic [4:0] drive;

    // 0 never high, 100 always high, between is duty
    assign user_level = ({1'b0, pct} < value[g]);
    // Function bit picks user level or the shared function
    assign level = cfg[g][gpio_port_pkg::CFG_FUNC_BIT] ? user_level : ALT_LEVEL_I[g];
    assign drive = resolve(cfg[g][2:0], level);

    // Registered pad controls, no glitch on mode change
    always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
        GPIO_O[g]        <= 1'b0;
        GPIO_OE_O[g]     <= 1'b0;
        GPIO_PULLUP_O[g] <= 1'b0;
        GPIO_PULLDN_O[g] <= 1'b0;
        GPIO_SLOW_O[g]   <= 1'b0;
        USER_CTRL_O[g]   <= 1'b0;
      end else begin
        GPIO_O[g]        <= drive[4];
        GPIO_OE_O[g]     <= drive[3];
        GPIO_PULLUP_O[g] <= drive[2];
        GPIO_PULLDN_O[g] <= drive[1];
        GPIO_SLOW_O[g]   <= drive[0];
        USER_CTRL_O[g]   <= cfg[g][gpio_port_pkg::CFG_FUNC_BIT];
      end
    end
  end

  // -------------------------------------------------------------
  // AXI4-Lite read side
  // -------------------------------------------------------------
  rd_state_type rd_state;
  logic [31:0]  rd_word;
  logic         rd_mapped;

  assign ARREADY_O = (rd_state == RD_IDLE);
  assign RVALID_O  = (rd_state == RD_DATA);

  // Read mux; argument word reads back, command word reads as zero
  always_comb begin
    rd_word   = 32'h0;
    rd_mapped = 1'b1;
    case (ARADDR_I)
      gpio_port_pkg::OFFS_ARG:    rd_word = arg;
      gpio_port_pkg::OFFS_RHDR:   rd_word = {16'h0, ans_len, ans_type};
      gpio_port_pkg::OFFS_RDATA:  rd_word = ans_data;
      gpio_port_pkg::OFFS_STATUS: rd_word = {11'h0, fall, 3'h0, rise, 3'h0, stable};
      gpio_port_pkg::OFFS_CMD:    rd_word = 32'h0;
      default:                    rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rd_state <= RD_IDLE;
      RDATA_O  <= 32'h0;
      RRESP_O  <= 2'h0;
    end else if (ARVALID_I && ARREADY_O) begin
      rd_state <= RD_DATA;
      RDATA_O  <= rd_word;
      RRESP_O  <= rd_mapped ? 2'h0 : 2'h2;
    end else if (RVALID_O && RREADY_I) begin
      rd_state <= RD_IDLE;
    end
  end

endmodule : packet_gpio_port

`default_nettype wire

// ===== dv/packet_gpio_port_asserts.sv
// Checker: bus answers, pad controls, debounce.
// Bound into packet_gpio_port; sees only its ports.
`default_nettype none
module gpio_port_chk #(
  parameter int unsigned SAMPLE_CYCLES = 16
) (
  // Clock and reset
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  // Register bus
  input wire logic        AWVALID_I,
  input wire logic        AWREADY_O,
  input wire logic        WVALID_I,
  input wire logic        WREADY_O,
  input wire logic [1:0]  BRESP_O,
  input wire logic        BVALID_O,
  input wire logic        BREADY_I,
  input wire logic        ARVALID_I,
  input wire logic        ARREADY_O,
  input wire logic [31:0] RDATA_O,
  input wire logic        RVALID_O,
  input wire logic        RREADY_I,
  // Pins
  input wire logic [4:0]  USER_CTRL_O,
  input wire logic [4:0]  PIN_LEVEL_O,
  input wire logic [4:0]  GPIO_OE_O,
  input wire logic [4:0]  GPIO_PULLUP_O,
  input wire logic [4:0]  GPIO_PULLDN_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  logic [4:0]  lvl_q;
  int unsigned since;
  // Cycles since the debounced levels moved, saturating
  always_ff @(posedge CLK_I) begin
    lvl_q <= PIN_LEVEL_O;
    if (RESET_I || PIN_LEVEL_O != lvl_q) since <= RESET_I ? SAMPLE_CYCLES : 1;
    else if (since < SAMPLE_CYCLES) since <= since + 1;
  end
  property p_b_hold; BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O); endproperty
  a_b_hold: assert property (p_b_hold) else $error("B answer dropped");
  property p_r_hold; RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O); endproperty
  a_r_hold: assert property (p_r_hold) else $error("R answer dropped");
  property p_w_ans; AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |=> BVALID_O; endproperty
  a_w_ans: assert property (p_w_ans) else $error("B late");
  property p_r_ans; ARVALID_I && ARREADY_O |=> RVALID_O; endproperty
  a_r_ans: assert property (p_r_ans) else $error("R late");
  property p_r_block; RVALID_O |-> !ARREADY_O; endproperty
  a_r_block: assert property (p_r_block) else $error("second read taken");
  property p_pulls; (GPIO_OE_O & (GPIO_PULLUP_O | GPIO_PULLDN_O)) == 5'h00; endproperty
  a_pulls: assert property (p_pulls) else $error("pull beside drive");
  property p_debounce; PIN_LEVEL_O != lvl_q |-> since >= SAMPLE_CYCLES; endproperty
  a_debounce: assert property (p_debounce) else $error("level moved off tick");
  property p_user; $changed(USER_CTRL_O) |-> BVALID_O || $past(BVALID_O) || $past(RESET_I, 2); endproperty
  a_user: assert property (p_user) else $error("function bit moved alone");
  c_write: cover property (BVALID_O && !BREADY_I);
  c_read: cover property (RVALID_O && !RREADY_I);
  c_level: cover property (PIN_LEVEL_O != lvl_q);
endmodule : gpio_port_chk

bind packet_gpio_port gpio_port_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) gpio_port_chk_i (.*);
`default_nettype wire

// ===== dv/pad_world.sv
// Board beyond the five pads: pull resistors and a switch the bench commands.
// Assumes active-high pad controls; a floating line reads noise.
`default_nettype none
module pad_world (
  // Clock
  input  wire logic       clk_i,
  // Pad controls
  input  wire logic [4:0] oe_i,
  input  wire logic [4:0] out_i,
  input  wire logic [4:0] pu_i,
  input  wire logic [4:0] pd_i,
  // Switch
  input  wire logic [4:0] sw_en_i,
  input  wire logic [4:0] sw_lvl_i,
  // Line levels
  output logic      [4:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] noise = 5'h15;
  // Fresh noise each cycle, so a floating line never looks settled
  always_ff @(posedge clk_i) begin
    noise <= 5'($urandom);
  end
  // Line level from every party's enable
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pad_o[i] = oe_i[i] ? out_i[i] : sw_en_i[i] ? sw_lvl_i[i] : pu_i[i] ? 1'b1 : pd_i[i] ? 1'b0 : noise[i];
    end
  end
endmodule : pad_world
`default_nettype wire

// ===== dv/tb_packet_gpio_port.sv
// Self-checking bench for the packet GPIO port.
// Assumes the pad model on the pins and the bound checker.
`default_nettype none
module tb_packet_gpio_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned STEP = 4;
  localparam int unsigned SAMP = 16;
  logic        clk = 1'b0, rst = 1'b1, por = 1'b1;
  logic [7:0]  aw_addr = 8'h00, ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0, rdata;
  logic        aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
  logic        awrdy, wrdy, bv, arrdy, rv;
  logic [1:0]  bresp, rresp;
  logic [4:0]  alt = 5'h00, sw_en = 5'h00, sw_lvl = 5'h00;
  logic [4:0]  pad, gpo, oe, pu, pd, slow, usr, lvl;
  int          err_total = 0;
  int          compares = 0;
  packet_gpio_port #(.PWM_STEP_CYCLES(STEP), .SAMPLE_CYCLES(SAMP)) packet_gpio_port_i (
    .CLK_I(clk), .RESET_I(rst), .POR_I(por), .AWADDR_I(aw_addr), .AWVALID_I(aw_v),
    .AWREADY_O(awrdy), .WDATA_I(w_data), .WSTRB_I(4'hf), .WVALID_I(w_v), .WREADY_O(wrdy),
    .BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(b_rdy), .ARADDR_I(ar_addr), .ARVALID_I(ar_v),
    .ARREADY_O(arrdy), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(r_rdy),
    .ALT_LEVEL_I(alt), .PIN_LEVEL_O(lvl), .USER_CTRL_O(usr), .GPIO_I(pad), .GPIO_O(gpo),
    .GPIO_OE_O(oe), .GPIO_PULLUP_O(pu), .GPIO_PULLDN_O(pd), .GPIO_SLOW_O(slow));
  pad_world pad_world_i (.clk_i(clk), .oe_i(oe), .out_i(gpo), .pu_i(pu), .pd_i(pd),
    .sw_en_i(sw_en), .sw_lvl_i(sw_lvl), .pad_o(pad));
  // 250 MHz clock
  always #2 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // Bus master: ready raised at random, then held
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] r);
    bit done;
    aw_addr <= a;
    w_data <= dat;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    do begin
      @(posedge clk);
      done = bv === 1'b1 && b_rdy;
      if (aw_v && awrdy === 1'b1) aw_v <= 1'b0;
      if (w_v && wrdy === 1'b1) w_v <= 1'b0;
      b_rdy <= !done && (b_rdy || 1'($urandom));
    end while (!done);
    r = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    ar_addr <= a;
    ar_v <= 1'b1;
    do begin
      @(posedge clk);
      done = rv === 1'b1 && r_rdy;
      if (ar_v && arrdy === 1'b1) ar_v <= 1'b0;
      r_rdy <= !done && (r_rdy || 1'($urandom));
    end while (!done);
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic cmd(input logic [7:0] t, input logic [2:0] n, input logic [31:0] arg, output logic [31:0] h);
    logic [1:0] r;
    wr(gpio_port_pkg::OFFS_ARG, arg, r);
    wr(gpio_port_pkg::OFFS_CMD, {21'h0, n, t}, r);
    rd(gpio_port_pkg::OFFS_RHDR, h, r);
  endtask : cmd
  task automatic query(input int unsigned p, output logic [31:0] d);
    logic [31:0] h;
    logic [1:0]  r;
    cmd(8'h23, 3'h1, p, h);
    chk("query hdr", h, 32'h0463);
    rd(gpio_port_pkg::OFFS_RDATA, d, r);
  endtask : query
  // Expected {oe, out, pull-up, pull-down, slow} per mode, level
  function automatic logic [4:0] pad_exp(input logic [2:0] m, input logic h);
    case (m)
      3'h0: return h ? 5'b11000 : 5'b00010;
      3'h1: return {1'b1, h, 3'b000};
      3'h3: return h ? 5'b00100 : 5'b10000;
      3'h4: return h ? 5'b11001 : 5'b00000;
      3'h5: return {1'b1, h, 3'b001};
      3'h7: return h ? 5'b00000 : 5'b10001;
      default: return 5'b00000;
    endcase
  endfunction : pad_exp
  task automatic padchk(input int unsigned p, input logic [2:0] m, input logic h);
    chk("pads", {oe[p], gpo[p] & oe[p], pu[p], pd[p], slow[p] & oe[p]}, pad_exp(m, h));
  endtask : padchk
  // Watchdog, far past the test length
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    complete_run();
  end
  initial begin : main
    logic [31:0] h, d;
    logic [1:0]  r;
    logic [2:0]  m;
    logic [7:0]  v;
    int unsigned p, hi;
    void'($urandom(76342));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    query(4, d);
    chk("boot cfg", d[27:24], 4'h7);
    // Every legal mode at both levels; 110 never sent
    for (int k = 0; k < 14; k++) begin
      m = (k % 7 == 6) ? 3'h7 : 3'(k % 7);
      v = (k < 7) ? 8'h00 : 8'h64;
      p = $urandom_range(4);
      cmd(8'h22, 3'h3, {13'h1, m, v, 8'(p)}, h);
      chk("set ack", h, 32'h62);
      padchk(p, m, v != 0);
      query(p, d);
      chk("read back", {d[27:16], d[7:0]}, {1'b1, m, v, 8'(p)});
    end
    $display("test sweep done");
    cmd(8'h22, 3'h2, {16'h0, 8'h00, 8'(5 + $urandom_range(250))}, h);
    chk("bad index", h, 32'ha2);
    cmd(8'h22, 3'h2, {16'h0, 8'(101 + $urandom_range(154)), 8'h00}, h);
    chk("bad value", h, 32'ha2);
    cmd(8'h23, 3'h1, 32'h5, h);
    chk("bad query", h, 32'ha3);
    cmd(8'h22, 3'h3, 32'h00090000, h);
    cmd(8'h22, 3'h2, 32'h00006400, h);
    chk("short ack", h, 32'h62);
    padchk(0, 3'h1, 1'b1);
    $display("test packets done");
    // Duty corners and a random duty, one period
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'd1 : (k == 1) ? 8'd99 : 8'($urandom_range(97) + 2);
      cmd(8'h22, 3'h2, {16'h0, v, 8'h00}, h);
      hi = 0;
      repeat (100 * STEP) begin
        @(posedge clk);
        hi += gpo[0];
      end
      chk("pwm duty", hi, v * STEP);
    end
    $display("test pwm done");
    cmd(8'h22, 3'h3, 32'h00010003, h);
    for (int k = 0; k < 3; k++) begin
      alt <= 5'($urandom);
      repeat (4) @(posedge clk);
      chk("shared", {usr[3], oe[3], gpo[3]}, {2'b01, alt[3]});
    end
    $display("test shared done");
    // A sub-tick glitch is dropped; real edges latch until queried
    cmd(8'h22, 3'h3, 32'h000a0002, h);
    sw_en <= 5'h04;
    repeat (4 * SAMP) @(posedge clk);
    query(2, d);
    sw_lvl <= 5'h04;
    repeat (10) @(posedge clk);
    sw_lvl <= 5'h00;
    repeat (4 * SAMP) @(posedge clk);
    query(2, d);
    chk("glitch", d[10:8], 3'b000);
    for (int k = 0; k < 3; k++) begin
      sw_lvl <= (k == 2) ? 5'h00 : 5'h04;
      repeat (4 * SAMP) @(posedge clk);
      query(2, d);
      chk("edges", d[10:8], (k == 0) ? 3'b101 : (k == 1) ? 3'b001 : 3'b010);
      chk("lvl", lvl[2], k != 2);
    end
    $display("test inputs done");
    cmd(8'h22, 3'h3, 32'h000d6400, h);
    cmd(8'h22, 3'h3, 32'h00030001, h);
    cmd(8'h04, 3'h0, 32'h0, h);
    chk("store ack", h, 32'h44);
    cmd(8'h22, 3'h3, 32'h00090000, h);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    query(0, d);
    chk("boot copy", d[27:16], 12'hd64);
    $display("test boot done");
    rd(8'h14, d, r);
    chk("unmapped resp", r, 2'h2);
    chk("unmapped data", d, 32'h0);
    wr(gpio_port_pkg::OFFS_RHDR, 32'h0, r);
    chk("read-only write", r, 2'h2);
    $display("test bus done");
    complete_run();
  end
endmodule : tb_packet_gpio_port
`default_nettype wire
